// ---- tbu_core.v ----
// Transfer and single-bit operation unit with an APB register port.
// Assumes a single 20 MHz clock, synchronous active-high reset, APB master.
// Function
// - Move copies source or immediate to destination
// - Nibble move replaces one nibble of the destination low byte
// - Address load writes address, not contents
// - Push saves value; pop restores from stack
// - Multi-register save and restore by mask
// - Address push places effective address on stack
// - Far load and store use extended area
// - Store only when zero flag matches variant
// - Zero-select picks first or second source
// - Swap exchanges source and destination
// - Size bit selects byte or word
// - Bit AND/OR/XOR with carry into carry
// - Bit invert complements destination bit
// - Sign xor overflow drives signed conditions of conditional bit writes
// - Test-then-clear loads flags, clears bit
// - Test-then-set loads flags, sets bit
// - Clear/set/invert/conditional bit writes keep flags unless flags targeted
// - Flag-direct reaches only low eight flags
// - Bit count gives byte address and position
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "tbu_defines.vh"
module tbu_core #(
  parameter SAW = 4,
  parameter FAW = 8
) (
  input  wire        clk,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire        pslverr,
  output reg  [31:0] prdata
);
  localparam S_IDLE  = 3'd0;
  localparam S_EXEC  = 3'd1;
  localparam S_RD    = 3'd2;
  localparam S_MSAVE = 3'd3;
  localparam S_MREST = 3'd4;

  reg  [2:0]     state_q;
  reg  [31:0]    ctrl_q;
  reg  [15:0]    src_a_q;
  reg  [15:0]    src_b_q;
  reg  [15:0]    dst_q;
  reg  [7:0]     flags_q;
  reg  [15:0]    ea_q;
  reg  [15:0]    bitsel_q;
  reg  [15:0]    res_q;
  reg  [15:0]    res2_q;
  reg            done_q;
  reg            dwr_q;
  reg  [SAW-1:0] sp_q;
  reg  [19:0]    far_q;
  reg  [12:0]    baddr_q;
  reg  [15:0]    gpr_q [0:7];
  reg  [2:0]     idx_q;
  reg            ph_q;
  reg  [31:0]    rd_mux;
  reg            map_ok;
  reg            st_we;
  reg  [SAW-1:0] st_waddr;
  reg  [15:0]    st_wdata;
  reg            far_we;
  reg  [15:0]    far_wdata;
  reg  [15:0]    tgt;
  reg  [15:0]    tgt_new;
  reg  [3:0]     pos;
  reg            bv;
  reg            sb;
  reg            nb;
  reg            wb;
  reg            c_we;
  reg            c_new;
  reg            zc_we;
  wire [15:0]    st_rdata;
  wire [15:0]    far_rdata;
  wire [4:0]     op     = ctrl_q[`TBU_CTL_OP_LSB +: 5];
  wire           word   = ctrl_q[`TBU_CTL_WORD];
  wire [1:0]     nib    = ctrl_q[`TBU_CTL_NIB_LSB +: 2];
  wire [7:0]     mask   = ctrl_q[`TBU_CTL_MASK_LSB +: 8];
  wire [3:0]     cc     = ctrl_q[`TBU_CTL_COND_LSB +: 4];
  wire [1:0]     bmod   = ctrl_q[`TBU_CTL_BMOD_LSB +: 2];
  wire           wr_acc = psel & penable & pwrite;
  wire           zf     = flags_q[`TBU_FLG_Z];
  wire           pwpdata_go = pwdata[`TBU_CTL_GO];
  wire           start  = wr_acc && paddr == `TBU_OFS_CTRL && pwpdata_go && state_q == S_IDLE;
  wire           gpr_hit = paddr[7:5] == 3'b010 && paddr[1:0] == 2'b00;

  // Byte operations keep the upper destination byte
  function [15:0] size_merge;
    input [15:0] old_v;
    input [15:0] new_v;
    input        wsel;
    begin
      size_merge = wsel ? new_v : {old_v[15:8], new_v[7:0]};
    end
  endfunction

  function cond_eval;
    input [3:0] c;
    input [7:0] f;
    reg         so;
    begin
      so = f[`TBU_FLG_S] ^ f[`TBU_FLG_O];
      case (c)
        `TBU_CC_GEU: cond_eval = f[`TBU_FLG_C];
        `TBU_CC_LTU: cond_eval = ~f[`TBU_FLG_C];
        `TBU_CC_EQ:  cond_eval = f[`TBU_FLG_Z];
        `TBU_CC_NE:  cond_eval = ~f[`TBU_FLG_Z];
        `TBU_CC_GTU: cond_eval = f[`TBU_FLG_C] & ~f[`TBU_FLG_Z];
        `TBU_CC_LEU: cond_eval = ~(f[`TBU_FLG_C] & ~f[`TBU_FLG_Z]);
        `TBU_CC_PZ:  cond_eval = ~f[`TBU_FLG_S];
        `TBU_CC_N:   cond_eval = f[`TBU_FLG_S];
        `TBU_CC_GE:  cond_eval = ~so;
        `TBU_CC_LE:  cond_eval = so | f[`TBU_FLG_Z];
        `TBU_CC_GT:  cond_eval = ~(so | f[`TBU_FLG_Z]);
        `TBU_CC_LT:  cond_eval = so;
        `TBU_CC_O:   cond_eval = f[`TBU_FLG_O];
        `TBU_CC_NO:  cond_eval = ~f[`TBU_FLG_O];
        default:     cond_eval = 1'b0;
      endcase
    end
  endfunction

  // Bit operand and its new value
  always @* begin
    // Flag-direct sees only the eight low flag bits
    tgt   = (bmod == `TBU_BMOD_FLAG) ? {8'h00, flags_q} : dst_q;
    pos   = (bmod == `TBU_BMOD_REG) ? bitsel_q[3:0] : {1'b0, bitsel_q[2:0]};
    bv    = tgt[pos];
    sb    = (op == `TBU_OP_BIT_NAND || op == `TBU_OP_BIT_NOR ||
             op == `TBU_OP_BIT_XNOR) ? ~bv : bv;
    nb    = 1'b0;
    wb    = 1'b0;
    c_we  = 1'b0;
    c_new = flags_q[`TBU_FLG_C];
    zc_we = 1'b0;
    case (op)
      `TBU_OP_BIT_AND, `TBU_OP_BIT_NAND: begin
        c_we  = 1'b1;
        c_new = sb & flags_q[`TBU_FLG_C];
      end
      `TBU_OP_BIT_OR, `TBU_OP_BIT_NOR: begin
        c_we  = 1'b1;
        c_new = sb | flags_q[`TBU_FLG_C];
      end
      `TBU_OP_BIT_XOR, `TBU_OP_BIT_XNOR: begin
        c_we  = 1'b1;
        c_new = sb ^ flags_q[`TBU_FLG_C];
      end
      `TBU_OP_BIT_CLR: begin
        wb = 1'b1;
      end
      `TBU_OP_BIT_SET: begin
        wb = 1'b1;
        nb = 1'b1;
      end
      `TBU_OP_BIT_INV: begin
        wb = 1'b1;
        nb = ~bv;
      end
      `TBU_OP_BIT_COND: begin
        wb = 1'b1;
        nb = cond_eval(cc, flags_q);
      end
      `TBU_OP_PROBE, `TBU_OP_NPROBE: begin
        zc_we = 1'b1;
      end
      `TBU_OP_TST_CLR: begin
        zc_we = 1'b1;
        wb    = 1'b1;
      end
      `TBU_OP_TST_SET: begin
        zc_we = 1'b1;
        wb    = 1'b1;
        nb    = 1'b1;
      end
      default: begin
        wb = 1'b0;
      end
    endcase
    tgt_new      = tgt;
    tgt_new[pos] = wb ? nb : bv;
  end

  // Memory write ports
  always @* begin
    st_we     = 1'b0;
    st_waddr  = sp_q - {{(SAW-1){1'b0}}, 1'b1};
    st_wdata  = src_a_q;
    far_we    = 1'b0;
    far_wdata = word ? src_a_q : {8'h00, src_a_q[7:0]};
    if (state_q == S_EXEC) begin
      if (op == `TBU_OP_PUSH) begin
        st_we    = 1'b1;
        st_wdata = word ? src_a_q : {8'h00, src_a_q[7:0]};
      end
      if (op == `TBU_OP_APUSH) begin
        st_we    = 1'b1;
        st_wdata = ea_q;
      end
      far_we = (op == `TBU_OP_FAR_ST);
    end
    if (state_q == S_MSAVE && mask[idx_q]) begin
      st_we    = 1'b1;
      st_wdata = gpr_q[idx_q];
    end
  end

  always @* begin
    map_ok = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      `TBU_OFS_CTRL:   rd_mux = ctrl_q;
      `TBU_OFS_SRC_A:  rd_mux = {16'h0000, src_a_q};
      `TBU_OFS_SRC_B:  rd_mux = {16'h0000, src_b_q};
      `TBU_OFS_DST:    rd_mux = {16'h0000, dst_q};
      `TBU_OFS_FLAGS:  rd_mux = {24'h000000, flags_q};
      `TBU_OFS_EA:     rd_mux = {16'h0000, ea_q};
      `TBU_OFS_BITSEL: rd_mux = {16'h0000, bitsel_q};
      `TBU_OFS_RES:    rd_mux = {16'h0000, res_q};
      `TBU_OFS_RES2:   rd_mux = {16'h0000, res2_q};
      `TBU_OFS_STAT:   rd_mux = {29'h0, dwr_q, done_q, state_q != S_IDLE};
      `TBU_OFS_SP:     rd_mux = {{(32-SAW){1'b0}}, sp_q};
      `TBU_OFS_FAR:    rd_mux = {12'h000, far_q};
      `TBU_OFS_BADDR:  rd_mux = {19'h0, baddr_q};
      default: begin
        map_ok = gpr_hit;
        rd_mux = gpr_hit ? {16'h0000, gpr_q[paddr[4:2]]} : 32'h0000_0000;
      end
    endcase
  end

  // Zero wait states; read data captured in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~map_ok;

  always @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= rd_mux;
    end
  end

  always @(posedge clk) begin : regs
    integer i;
    if (rst) begin
      state_q  <= S_IDLE;
      ctrl_q   <= `TBU_RST_CTRL;
      src_a_q  <= `TBU_RST_WORD;
      src_b_q  <= `TBU_RST_WORD;
      dst_q    <= `TBU_RST_WORD;
      flags_q  <= `TBU_RST_FLAGS;
      ea_q     <= `TBU_RST_WORD;
      bitsel_q <= `TBU_RST_WORD;
      res_q    <= `TBU_RST_WORD;
      res2_q   <= `TBU_RST_WORD;
      done_q   <= 1'b0;
      dwr_q    <= 1'b0;
      sp_q     <= {SAW{1'b0}};
      far_q    <= 20'h00000;
      baddr_q  <= 13'h0000;
      idx_q    <= 3'd0;
      ph_q     <= 1'b0;
      for (i = 0; i < 8; i = i + 1) begin
        gpr_q[i] <= `TBU_RST_WORD;
      end
    end else begin
      // Operand writes are taken at any time, GPR writes only when idle; software keeps them still while busy
      if (wr_acc) begin
        case (paddr)
          `TBU_OFS_SRC_A:  src_a_q <= pwdata[15:0];
          `TBU_OFS_SRC_B:  src_b_q <= pwdata[15:0];
          `TBU_OFS_DST:    dst_q <= pwdata[15:0];
          `TBU_OFS_FLAGS:  flags_q <= pwdata[7:0];
          `TBU_OFS_EA:     ea_q <= pwdata[15:0];
          `TBU_OFS_BITSEL: bitsel_q <= pwdata[15:0];
          `TBU_OFS_SP:     sp_q <= pwdata[SAW-1:0];
          `TBU_OFS_FAR:    far_q <= pwdata[19:0];
          default: begin
            if (gpr_hit && state_q == S_IDLE) begin
              gpr_q[paddr[4:2]] <= pwdata[15:0];
            end
          end
        endcase
      end
      if (start) begin
        ctrl_q  <= pwdata;
        done_q  <= 1'b0;
        dwr_q   <= 1'b0;
        state_q <= S_EXEC;
      end
      case (state_q)
        S_IDLE: begin
          ph_q <= 1'b0;
        end
        S_EXEC: begin
          state_q <= S_IDLE;
          done_q  <= 1'b1;
          dwr_q   <= 1'b1;
          baddr_q <= bitsel_q[15:3];
          case (op)
            `TBU_OP_MOVE:    res_q <= size_merge(dst_q, src_a_q, word);
            `TBU_OP_NIBBLE: begin
              res_q <= dst_q;
              if (nib[0]) begin
                res_q[7:4] <= nib[1] ? src_a_q[7:4] : src_a_q[3:0];
              end else begin
                res_q[3:0] <= nib[1] ? src_a_q[7:4] : src_a_q[3:0];
              end
            end
            `TBU_OP_EA_LOAD: res_q <= ea_q;
            `TBU_OP_PUSH, `TBU_OP_APUSH: begin
              sp_q  <= st_waddr;
              dwr_q <= 1'b0;
            end
            `TBU_OP_POP, `TBU_OP_FAR_LD: begin
              state_q <= S_RD;
              done_q  <= 1'b0;
            end
            `TBU_OP_FAR_ST:  dwr_q <= 1'b0;
            `TBU_OP_MSAVE: begin
              idx_q   <= 3'd7;
              state_q <= S_MSAVE;
              done_q  <= 1'b0;
            end
            `TBU_OP_MREST: begin
              idx_q   <= 3'd0;
              ph_q    <= 1'b0;
              state_q <= S_MREST;
              done_q  <= 1'b0;
            end
            `TBU_OP_ST_NZ: begin
              res_q <= zf ? dst_q : size_merge(dst_q, src_a_q, word);
              dwr_q <= ~zf;
            end
            `TBU_OP_ST_Z: begin
              res_q <= zf ? size_merge(dst_q, src_a_q, word) : dst_q;
              dwr_q <= zf;
            end
            `TBU_OP_SEL_Z: res_q <= size_merge(dst_q, zf ? src_a_q : src_b_q, word);
            `TBU_OP_SWAP: begin
              res_q  <= size_merge(dst_q, src_a_q, word);
              res2_q <= size_merge(src_a_q, dst_q, word);
            end
            default: begin
              // Bit group: a flag-direct write lands in the flag bits only
              if (bmod == `TBU_BMOD_FLAG) begin
                dwr_q <= 1'b0;
                if (wb) begin
                  flags_q <= tgt_new[7:0];
                end
              end else begin
                res_q <= tgt_new;
                dwr_q <= wb;
              end
              if (c_we) begin
                flags_q[`TBU_FLG_C] <= c_new;
              end
              if (zc_we) begin
                flags_q[`TBU_FLG_Z] <= (op == `TBU_OP_NPROBE) ? bv : ~bv;
                flags_q[`TBU_FLG_C] <= (op == `TBU_OP_NPROBE) ? ~bv : bv;
              end
            end
          endcase
        end
        S_RD: begin
          res_q   <= size_merge(dst_q, op == `TBU_OP_POP ? st_rdata : far_rdata, word);
          if (op == `TBU_OP_POP) begin
            sp_q <= sp_q + {{(SAW-1){1'b0}}, 1'b1};
          end
          done_q  <= 1'b1;
          dwr_q   <= 1'b1;
          state_q <= S_IDLE;
        end
        S_MSAVE: begin
          // Highest register goes first so restore order mirrors it
          if (mask[idx_q]) begin
            sp_q <= st_waddr;
          end
          idx_q <= idx_q - 3'd1;
          if (idx_q == 3'd0) begin
            state_q <= S_IDLE;
            done_q  <= 1'b1;
          end
        end
        S_MREST: begin
          // Two passes per set bit: address out, then registered data back
          if (mask[idx_q] && !ph_q) begin
            ph_q <= 1'b1;
          end else begin
            if (mask[idx_q]) begin
              gpr_q[idx_q] <= st_rdata;
              sp_q <= sp_q + {{(SAW-1){1'b0}}, 1'b1};
            end
            ph_q  <= 1'b0;
            idx_q <= idx_q + 3'd1;
            if (idx_q == 3'd7) begin
              state_q <= S_IDLE;
              done_q  <= 1'b1;
            end
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  tbu_mem #(.AW(SAW), .DW(16)) u_stack (
    .clk     (clk),
    .we      (st_we),
    .waddr   (st_waddr),
    .wdata   (st_wdata),
    .raddr   (sp_q),
    .rdata_q (st_rdata)
  );

  tbu_mem #(.AW(FAW), .DW(16)) u_far (
    .clk     (clk),
    .we      (far_we),
    .waddr   (far_q[FAW-1:0]),
    .wdata   (far_wdata),
    .raddr   (far_q[FAW-1:0]),
    .rdata_q (far_rdata)
  );
endmodule

// ---- tbu_defines.vh ----
// Constants for the transfer and bit operation unit: register offsets,
// control fields, flag positions, operation and condition codes.
// Included by the unit's design files; definitions only.
`ifndef TBU_DEFINES_VH
`define TBU_DEFINES_VH

`define TBU_OFS_CTRL    8'h00
`define TBU_OFS_SRC_A   8'h04
`define TBU_OFS_SRC_B   8'h08
`define TBU_OFS_DST     8'h0c
`define TBU_OFS_FLAGS   8'h10
`define TBU_OFS_EA      8'h14
`define TBU_OFS_BITSEL  8'h18
`define TBU_OFS_RES     8'h1c
`define TBU_OFS_RES2    8'h20
`define TBU_OFS_STAT    8'h24
`define TBU_OFS_SP      8'h28
`define TBU_OFS_FAR     8'h2c
`define TBU_OFS_BADDR   8'h30
`define TBU_OFS_GPR     8'h40

`define TBU_CTL_OP_LSB   0
`define TBU_CTL_WORD     5
`define TBU_CTL_NIB_LSB  6
`define TBU_CTL_MASK_LSB 8
`define TBU_CTL_COND_LSB 16
`define TBU_CTL_BMOD_LSB 20
`define TBU_CTL_GO       31

`define TBU_BMOD_MEM  2'h0
`define TBU_BMOD_REG  2'h1
`define TBU_BMOD_FLAG 2'h2

`define TBU_FLG_C 0
`define TBU_FLG_D 1
`define TBU_FLG_Z 2
`define TBU_FLG_S 3
`define TBU_FLG_B 4
`define TBU_FLG_O 5
`define TBU_FLG_I 6
`define TBU_FLG_U 7

`define TBU_STAT_BUSY 0
`define TBU_STAT_DONE 1
`define TBU_STAT_DWR  2

`define TBU_RST_FLAGS 8'h00
`define TBU_RST_WORD  16'h0000
`define TBU_RST_CTRL  32'h0000_0000

`define TBU_OP_MOVE     5'h00
`define TBU_OP_NIBBLE   5'h01
`define TBU_OP_EA_LOAD  5'h02
`define TBU_OP_PUSH     5'h03
`define TBU_OP_POP      5'h04
`define TBU_OP_MSAVE    5'h05
`define TBU_OP_MREST    5'h06
`define TBU_OP_APUSH    5'h07
`define TBU_OP_FAR_LD   5'h08
`define TBU_OP_FAR_ST   5'h09
`define TBU_OP_ST_NZ    5'h0a
`define TBU_OP_ST_Z     5'h0b
`define TBU_OP_SEL_Z    5'h0c
`define TBU_OP_SWAP     5'h0d
`define TBU_OP_BIT_AND  5'h0e
`define TBU_OP_BIT_OR   5'h0f
`define TBU_OP_BIT_XOR  5'h10
`define TBU_OP_BIT_NAND 5'h11
`define TBU_OP_BIT_NOR  5'h12
`define TBU_OP_BIT_XNOR 5'h13
`define TBU_OP_BIT_CLR  5'h14
`define TBU_OP_BIT_SET  5'h15
`define TBU_OP_BIT_INV  5'h16
`define TBU_OP_BIT_COND 5'h17
`define TBU_OP_PROBE    5'h18
`define TBU_OP_TST_CLR  5'h19
`define TBU_OP_TST_SET  5'h1a
`define TBU_OP_NPROBE   5'h1b

`define TBU_CC_GEU 4'h0
`define TBU_CC_LTU 4'h1
`define TBU_CC_EQ  4'h2
`define TBU_CC_NE  4'h3
`define TBU_CC_GTU 4'h4
`define TBU_CC_LEU 4'h5
`define TBU_CC_PZ  4'h6
`define TBU_CC_N   4'h7
`define TBU_CC_GE  4'h8
`define TBU_CC_LE  4'h9
`define TBU_CC_GT  4'ha
`define TBU_CC_LT  4'hb
`define TBU_CC_O   4'hc
`define TBU_CC_NO  4'hd

`endif

// ---- tbu_mem.v ----
// Small single-port-write, registered-read word memory.
// Used for the stack area and the extended data area of the unit.
`timescale 1ns/1ps
module tbu_mem #(
  parameter AW = 4,
  parameter DW = 16
) (
  input  wire          clk,
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [DW-1:0] wdata,
  input  wire [AW-1:0] raddr,
  output reg  [DW-1:0] rdata_q
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // Read data one cycle after the address; no reset, contents undefined
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_q <= mem[raddr];
  end
endmodule

// ---- tbu_core_sva.sv ----
// Checker for the APB port of the transfer and bit operation unit.
// Sees only the top module's ports; bound to every tbu_core instance.
`timescale 1ns/1ps
`include "tbu_defines.vh"
module tbu_core_sva #(
  parameter SAW = 4
) (
  input wire        clk,
  input wire        rst,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire        pslverr,
  input wire [31:0] prdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire acc = psel && penable;
  wire alg = paddr[1:0] == 2'h0;
  wire gpr = paddr >= `TBU_OFS_GPR && paddr <= 8'h5c;
  // Misaligned offsets are left alone: their answer is not pinned down
  wire map = alg && (paddr <= `TBU_OFS_BADDR || gpr);
  wire wrd = alg && ((paddr >= `TBU_OFS_SRC_A && paddr <= `TBU_OFS_DST) ||
                     (paddr >= `TBU_OFS_EA && paddr <= `TBU_OFS_RES2) || gpr);
  sequence s_rd(logic [7:0] a);
    psel && !penable && !pwrite && paddr == a ##1 acc && paddr == a;
  endsequence
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_unmapped_err: assert property (acc && alg && !map |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (acc && map |-> !pslverr)
    else $error("mapped access refused");
  a_idle_quiet: assert property (!acc |-> !pslverr)
    else $error("pslverr outside access phase");
  a_flags_width: assert property (s_rd(`TBU_OFS_FLAGS) |-> prdata[31:8] == 24'h0)
    else $error("flag register wider than eight bits");
  a_baddr_width: assert property (s_rd(`TBU_OFS_BADDR) |-> prdata[31:13] == 19'h0)
    else $error("byte address too wide");
  a_sp_width: assert property (s_rd(`TBU_OFS_SP) |-> (prdata >> SAW) == 32'h0)
    else $error("stack pointer too wide");
  a_word_width: assert property (acc && !pwrite && wrd |-> prdata[31:16] == 16'h0)
    else $error("operand wider than a word");
  a_stat_width: assert property (s_rd(`TBU_OFS_STAT) |-> prdata[31:3] == 29'h0)
    else $error("status bits above flags");
endmodule

bind tbu_core tbu_core_sva #(.SAW(SAW)) u_sva (
  .clk     (clk),
  .rst     (rst),
  .psel    (psel),
  .penable (penable),
  .pwrite  (pwrite),
  .paddr   (paddr),
  .pwdata  (pwdata),
  .pready  (pready),
  .pslverr (pslverr),
  .prdata  (prdata)
);

// ---- tbu_core_tb_top.sv ----
// Self-checking bench for the transfer and bit operation unit.
// Drives the APB port directly; one 20 MHz clock, synchronous reset.
`timescale 1ns/1ps
`include "tbu_defines.vh"
module tbu_core_tb_top;
  logic        clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  wire         pready;
  wire         pslverr;
  wire  [31:0] prdata;
  integer      n_mismatch;
  integer      checked;
  logic [31:0] rdat;
  logic        rerr;
  integer      k;
  logic [4:0]  opc;
  logic        bb;
  logic        cy;
  logic        ex;
  logic [3:0]  sn;
  logic [7:0]  pat [0:7] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h08, 8'h20, 8'h28, 8'h0c};
  logic [31:0] bex [0:2] = '{32'h00e0, 32'h00f1, 32'h00d0};
  logic [3:0]  bsl [0:2] = '{4'h4, 4'h0, 4'h5};

  tbu_core #(.SAW(4), .FAW(8)) dut (
    .clk     (clk),
    .rst     (rst),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .pready  (pready),
    .pslverr (pslverr),
    .prdata  (prdata)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic test_done;
    if (n_mismatch == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] g);
    checked = checked + 1;
    if (g !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("Error reg %h expected %h seen %h", a, e, g);
    end
  endtask

  // Setup waits one edge first so psel is never dropped and raised in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    integer n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n = n + 1;
    end while (pready !== 1'b1 && n < 50);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_mismatch = n_mismatch + 1;
      test_done;
    end
  endtask

  task automatic w(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic r(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(a, e, rdat);
  endtask

  // Starts an operation and polls busy; never starts the next one early
  task automatic run(input logic [31:0] ctl);
    integer n;
    w(`TBU_OFS_CTRL, ctl);
    n = 0;
    do begin
      apb(1'b0, `TBU_OFS_STAT, 32'h0);
      n = n + 1;
    end while (rdat[`TBU_STAT_BUSY] !== 1'b0 && n < 40);
    if (rdat[`TBU_STAT_BUSY] !== 1'b0) begin
      n_mismatch = n_mismatch + 1;
      test_done;
    end
  endtask

  function automatic logic [31:0] cw(input logic [4:0] o, input logic wd,
                                     input logic [1:0] nb, input logic [7:0] m,
                                     input logic [3:0] cc, input logic [1:0] bm);
    return {1'b1, 9'h0, bm, cc, m, nb, wd, o};
  endfunction

  function automatic logic cnd(input logic [3:0] cc, input logic [7:0] f);
    logic        so;
    logic [13:0] t;
    so = f[3] ^ f[5];
    t = {!f[5], f[5], so, !(so || f[2]), so || f[2], !so, f[3], !f[3],
         !(f[0] && !f[2]), f[0] && !f[2], !f[2], f[2], !f[0], f[0]};
    return t[cc];
  endfunction

  initial begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; n_mismatch = 0; checked = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    r(`TBU_OFS_FLAGS, 32'h0);
    r(`TBU_OFS_STAT, 32'h0);
    r(`TBU_OFS_SP, 32'h0);
    r(`TBU_OFS_CTRL, 32'h0);
    w(`TBU_OFS_SRC_A, 32'h12ab);
    w(`TBU_OFS_DST, 32'h5566);
    run(cw(`TBU_OP_MOVE, 1'b1, 2'h0, 8'h0, 4'h0, 2'h0));
    r(`TBU_OFS_RES, 32'h12ab);
    run(cw(`TBU_OP_MOVE, 1'b0, 2'h0, 8'h0, 4'h0, 2'h0));
    r(`TBU_OFS_RES, 32'h55ab);
    w(`TBU_OFS_SRC_A, 32'h005a);
    w(`TBU_OFS_DST, 32'h003c);
    for (k = 0; k < 4; k = k + 1) begin
      sn = k[1] ? 4'h5 : 4'ha;
      run(cw(`TBU_OP_NIBBLE, 1'b0, k[1:0], 8'h0, 4'h0, 2'h0));
      r(`TBU_OFS_RES, {24'h0, k[0] ? {sn, 4'hc} : {4'h3, sn}});
    end
    w(`TBU_OFS_EA, 32'h0abc);
    run(cw(`TBU_OP_EA_LOAD, 1'b1, 2'h0, 8'h0, 4'h0, 2'h0));
    r(`TBU_OFS_RES, 32'h0abc);
    w(`TBU_OFS_SRC_A, 32'hbeef);
    run(cw(`TBU_OP_PUSH, 1'b1, 2'h0, 8'h0, 4'h0, 2'h0));
    r(`TBU_OFS_SP, 32'hf);
    run(cw(`TBU_OP_POP, 1'b1, 2'h0, 8'h0, 4'h0, 2'h0));
    r(`TBU_OFS_RES, 32'hbeef);
    run(cw(`TBU_OP_APUSH, 1'b1, 2'h0, 8'h0, 4'h0, 2'h0));
    run(cw(`TBU_OP_POP, 1'b1, 2'h0, 8'h0, 4'h0, 2'h0));
    r(`TBU_OFS_RES, 32'h0abc);
    w(`TBU_OFS_GPR, 32'ha000);
    w(8'h5c, 32'ha007);
    run(cw(`TBU_OP_MSAVE, 1'b1, 2'h0, 8'h81, 4'h0, 2'h0));
    r(`TBU_OFS_SP, 32'he);
    w(`TBU_OFS_GPR, 32'h0);
    w(8'h5c, 32'h0);
    run(cw(`TBU_OP_MREST, 1'b1, 2'h0, 8'h81, 4'h0, 2'h0));
    r(`TBU_OFS_GPR, 32'ha000);
    r(8'h5c, 32'ha007);
    r(`TBU_OFS_SP, 32'h0);
    w(`TBU_OFS_FAR, 32'h10);
    w(`TBU_OFS_SRC_A, 32'hcafe);
    run(cw(`TBU_OP_FAR_ST, 1'b1, 2'h0, 8'h0, 4'h0, 2'h0));
    w(`TBU_OFS_SRC_A, 32'h0);
    run(cw(`TBU_OP_FAR_LD, 1'b1, 2'h0, 8'h0, 4'h0, 2'h0));
    r(`TBU_OFS_RES, 32'hcafe);
    w(`TBU_OFS_SRC_A, 32'h1111);
    w(`TBU_OFS_SRC_B, 32'h3333);
    w(`TBU_OFS_DST, 32'h2222);
    for (k = 0; k < 2; k = k + 1) begin
      w(`TBU_OFS_FLAGS, k << 2);
      run(cw(`TBU_OP_ST_NZ, 1'b1, 2'h0, 8'h0, 4'h0, 2'h0));
      r(`TBU_OFS_RES, k ? 32'h2222 : 32'h1111);
      r(`TBU_OFS_STAT, k ? 32'h2 : 32'h6);
      run(cw(`TBU_OP_ST_Z, 1'b1, 2'h0, 8'h0, 4'h0, 2'h0));
      r(`TBU_OFS_RES, k ? 32'h1111 : 32'h2222);
      run(cw(`TBU_OP_SEL_Z, 1'b1, 2'h0, 8'h0, 4'h0, 2'h0));
      r(`TBU_OFS_RES, k ? 32'h1111 : 32'h3333);
    end
    run(cw(`TBU_OP_SWAP, 1'b1, 2'h0, 8'h0, 4'h0, 2'h0));
    r(`TBU_OFS_RES, 32'h1111);
    r(`TBU_OFS_RES2, 32'h2222);
    w(`TBU_OFS_BITSEL, 32'h3);
    for (k = 0; k < 24; k = k + 1) begin
      bb = k % 2;
      cy = (k / 2) % 2;
      opc = `TBU_OP_BIT_AND + k / 4;
      w(`TBU_OFS_FLAGS, {26'h0, 6'h28} | cy);
      w(`TBU_OFS_DST, {28'h0, bb, 3'h0});
      run(cw(opc, 1'b1, 2'h0, 8'h0, 4'h0, 2'h1));
      bb = (opc >= `TBU_OP_BIT_NAND) ? !bb : bb;
      ex = ((k / 4) % 3 == 0) ? bb & cy : ((k / 4) % 3 == 1) ? bb | cy : bb ^ cy;
      r(`TBU_OFS_FLAGS, {24'h0, 7'h14, ex});
    end
    w(`TBU_OFS_DST, 32'h00f0);
    for (k = 0; k < 3; k = k + 1) begin
      w(`TBU_OFS_BITSEL, {28'h0, bsl[k]});
      run(cw(`TBU_OP_BIT_CLR + k, 1'b1, 2'h0, 8'h0, 4'h0, 2'h1));
      r(`TBU_OFS_RES, bex[k]);
      r(`TBU_OFS_FLAGS, 32'h29);
    end
    w(`TBU_OFS_DST, 32'h0);
    w(`TBU_OFS_BITSEL, 32'h2);
    for (k = 0; k < 112; k = k + 1) begin
      w(`TBU_OFS_FLAGS, {24'h0, pat[k % 8]});
      run(cw(`TBU_OP_BIT_COND, 1'b1, 2'h0, 8'h0, k / 8, 2'h1));
      r(`TBU_OFS_RES, {29'h0, cnd(k / 8, pat[k % 8]), 2'h0});
    end
    w(`TBU_OFS_FLAGS, 32'h0);
    w(`TBU_OFS_DST, 32'h0010);
    w(`TBU_OFS_BITSEL, 32'h4);
    run(cw(`TBU_OP_PROBE, 1'b1, 2'h0, 8'h0, 4'h0, 2'h1));
    r(`TBU_OFS_FLAGS, 32'h01);
    run(cw(`TBU_OP_NPROBE, 1'b1, 2'h0, 8'h0, 4'h0, 2'h1));
    r(`TBU_OFS_FLAGS, 32'h04);
    run(cw(`TBU_OP_TST_CLR, 1'b1, 2'h0, 8'h0, 4'h0, 2'h1));
    r(`TBU_OFS_RES, 32'h0000);
    r(`TBU_OFS_FLAGS, 32'h01);
    w(`TBU_OFS_BITSEL, 32'h0);
    run(cw(`TBU_OP_TST_SET, 1'b1, 2'h0, 8'h0, 4'h0, 2'h1));
    r(`TBU_OFS_RES, 32'h0011);
    r(`TBU_OFS_FLAGS, 32'h04);
    w(`TBU_OFS_FLAGS, 32'h0);
    w(`TBU_OFS_BITSEL, 32'he);
    run(cw(`TBU_OP_BIT_SET, 1'b1, 2'h0, 8'h0, 4'h0, 2'h2));
    r(`TBU_OFS_FLAGS, 32'h40);
    w(`TBU_OFS_BITSEL, 32'h0);
    run(cw(`TBU_OP_BIT_SET, 1'b1, 2'h0, 8'h0, 4'h0, 2'h2));
    r(`TBU_OFS_FLAGS, 32'h41);
    w(`TBU_OFS_BITSEL, 32'h7);
    run(cw(`TBU_OP_BIT_INV, 1'b1, 2'h0, 8'h0, 4'h0, 2'h2));
    r(`TBU_OFS_FLAGS, 32'hc1);
    w(`TBU_OFS_BITSEL, 32'h1234);
    run(cw(`TBU_OP_PROBE, 1'b1, 2'h0, 8'h0, 4'h0, 2'h0));
    r(`TBU_OFS_BADDR, 32'h0246);
    apb(1'b0, 8'h34, 32'h0);
    chk(8'h34, 32'h0, rdat);
    chk(8'h34, 32'h1, {31'h0, rerr});
    test_done;
  end
endmodule
